/* File: rtl/bth_defs.vh */
// constants for the bus termination, halt and reset controller
// assumes a single 50 MHz clock; all counts are in clock periods
`ifndef BTH_DEFS_VH
`define BTH_DEFS_VH

`define BTH_CLK_PERIOD_NS     20
`define BTH_RESET_OUT_CYCLES  124
`define BTH_SYSRST_CYCLES     10
`define BTH_VEC_SSP_ADDR      24'h000000
`define BTH_VEC_PC_ADDR       24'h000004
`define BTH_VEC_BUS_FAULT_IN_ADDR     24'h000008
`define BTH_IPL_RESET         3'h7
`define BTH_FC_SUPER_DATA     3'h5

// synchroniser bit positions
`define BTH_SY_ACK_N          0
`define BTH_SY_FAULT          1
`define BTH_SY_STOP           2
`define BTH_SY_RESET_N        3
`define BTH_SY_BREQ_N         4
`define BTH_SY_BGACK_N        5
`define BTH_SY_WIDTH          6
// idle levels of the synchronised inputs
`define BTH_SY_IDLE           6'h39

`endif

/* File: rtl/bth_bus_term.v */
// bus cycle termination, halt/single-step, re-run, double fault and reset control
// assumes pin inputs are asynchronous and that the core holds cyc_req until cyc_done or cyc_err
`timescale 1ns/1ps
`include "bth_defs.vh"

module bth_bus_term #(
	parameter RST_OUT_CYCLES = `BTH_RESET_OUT_CYCLES,
	parameter SYSRST_CYCLES  = `BTH_SYSRST_CYCLES
) (
	input  wire        mclk,
	input  wire        rst_b,
	input  wire        cyc_req,
	input  wire        cyc_write,
	input  wire        cyc_rmw,
	input  wire [23:0] cyc_addr,
	input  wire [15:0] cyc_wdata,
	input  wire [2:0]  cyc_fc,
	input  wire        insn_start,
	input  wire        reset_insn,
	input  wire        transfer_ack_n,
	input  wire        bus_fault_in,
	input  wire        stop_line,
	input  wire        reset_line_in,
	input  wire        bus_req_n,
	input  wire        bus_gack_n,
	input  wire [15:0] data_in,
	output reg         reset_line_out,
	output reg         reset_line_oe_n,
	output reg  [23:0] addr_out,
	output reg         addr_oe_n,
	output reg  [15:0] data_out,
	output reg         data_oe_n,
	output reg  [2:0]  fc_out,
	output reg         rw_out,
	output reg         addr_strobe_n,
	output reg         bus_grant_n,
	output reg         cyc_done,
	output reg         cyc_err,
	output reg  [15:0] cyc_rdata,
	output reg         trap_req,
	output reg  [23:0] trap_addr,
	output reg         halted,
	output reg         dbl_fault,
	output reg  [31:0] supervisor_stack_ptr,
	output reg  [31:0] prog_counter,
	output reg  [2:0]  ipl,
	output reg         boot_done
);

	localparam S_IDLE  = 4'h0;
	localparam S_ADDR  = 4'h1;
	localparam S_WAIT  = 4'h2;
	localparam S_FEXT  = 4'h3;
	localparam S_HALT  = 4'h4;
	localparam S_RERUN = 4'h5;
	localparam S_BUS_FAULT_IN  = 4'h6;
	localparam S_DFLT  = 4'h7;
	localparam S_SYSRS = 4'h8;
	localparam S_RSOUT = 4'h9;

	reg [`BTH_SY_WIDTH-1:0] sy1;
	reg [`BTH_SY_WIDTH-1:0] sy2;
	reg [`BTH_SY_WIDTH-1:0] sy3;
	reg [`BTH_SY_WIDTH-1:0] sy;
	reg [3:0]  state;
	reg        lt_write;
	reg        lt_rmw;
	reg [23:0] lt_addr;
	reg [15:0] lt_wdata;
	reg [2:0]  lt_fc;
	reg        fault_armed;
	reg        booting;
	reg [1:0]  boot_word;
	reg [7:0]  rs_out_cnt;
	reg [3:0]  sysrst_cnt;
	reg        granted;

	wire ack    = ~sy[`BTH_SY_ACK_N];
	wire fault  = sy[`BTH_SY_FAULT];
	wire stop   = sy[`BTH_SY_STOP];
	wire rst_in = ~sy[`BTH_SY_RESET_N];
	wire breq   = ~sy[`BTH_SY_BREQ_N];
	wire bgack  = ~sy[`BTH_SY_BGACK_N];
	wire bus_own = ~granted & ~bgack;
	wire sysrst_hit = (sysrst_cnt == SYSRST_CYCLES[3:0]);

	function [23:0] boot_addr;
		input [1:0] w;
		begin
			boot_addr = w[1] ? (`BTH_VEC_PC_ADDR + {22'h000000, w[0], 1'b0})
				: (`BTH_VEC_SSP_ADDR + {22'h000000, w[0], 1'b0});
		end
	endfunction

	// three-stage synchroniser; a change counts once stages two and three agree
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sy1 <= `BTH_SY_IDLE;
			sy2 <= `BTH_SY_IDLE;
			sy3 <= `BTH_SY_IDLE;
			sy  <= `BTH_SY_IDLE;
		end
		else
		begin
			sy1 <= {bus_gack_n, bus_req_n, reset_line_in, stop_line, bus_fault_in,
				transfer_ack_n};
			sy2 <= sy1;
			sy3 <= sy2;
			sy  <= (sy2 & sy3) | (sy & (sy2 | sy3));
		end
	end

	// arbitration grants only while the strobe is high and the state is not S_ADDR, halted or not
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			granted     <= 1'b0;
			bus_grant_n <= 1'b1;
		end
		else
		begin
			if (breq && addr_strobe_n && state != S_ADDR)
				granted <= 1'b1;
			else if (!breq && !bgack)
				granted <= 1'b0;
			bus_grant_n <= ~(granted & ~bgack & breq);
		end
	end

	// reset line and stop held together for the set count
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			sysrst_cnt <= 4'h0;
		else if (rst_in && stop && reset_line_oe_n)
		begin
			if (!sysrst_hit)
				sysrst_cnt <= sysrst_cnt + 4'h1;
		end
		else
			sysrst_cnt <= 4'h0;
	end

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state                <= S_SYSRS;
			lt_write             <= 1'b0;
			lt_rmw               <= 1'b0;
			lt_addr              <= 24'h000000;
			lt_wdata             <= 16'h0000;
			lt_fc                <= 3'h0;
			fault_armed          <= 1'b1;
			booting              <= 1'b1;
			boot_word            <= 2'h0;
			rs_out_cnt           <= 8'h00;
			reset_line_out       <= 1'b1;
			reset_line_oe_n      <= 1'b1;
			addr_out             <= 24'h000000;
			addr_oe_n            <= 1'b1;
			data_out             <= 16'h0000;
			data_oe_n            <= 1'b1;
			fc_out               <= 3'h0;
			rw_out               <= 1'b1;
			addr_strobe_n        <= 1'b1;
			cyc_done             <= 1'b0;
			cyc_err              <= 1'b0;
			cyc_rdata            <= 16'h0000;
			trap_req             <= 1'b0;
			trap_addr            <= 24'h000000;
			halted               <= 1'b0;
			dbl_fault            <= 1'b0;
			supervisor_stack_ptr <= 32'h00000000;
			prog_counter         <= 32'h00000000;
			ipl                  <= `BTH_IPL_RESET;
			boot_done            <= 1'b0;
		end
		else
		begin
			cyc_done  <= 1'b0;
			cyc_err   <= 1'b0;
			trap_req  <= 1'b0;
			boot_done <= 1'b0;
			if (insn_start && !booting)
				fault_armed <= 1'b0;
			if (sysrst_hit)
			begin
				// full reset: abandon any cycle and restart the vector fetch
				state         <= S_SYSRS;
				addr_strobe_n <= 1'b1;
				addr_oe_n     <= 1'b1;
				data_oe_n     <= 1'b1;
				booting       <= 1'b1;
				boot_word     <= 2'h0;
				fault_armed   <= 1'b1;
				ipl           <= `BTH_IPL_RESET;
				halted        <= 1'b1;
				dbl_fault     <= 1'b0;
			end
			else
			begin
				case (state)
				S_SYSRS:
				begin
					if (!rst_in && !stop)
					begin
						halted <= 1'b0;
						state  <= S_IDLE;
					end
				end
				S_IDLE:
				begin
					addr_oe_n <= ~bus_own | stop;
					if (reset_insn && !booting)
					begin
						rs_out_cnt      <= 8'h00;
						reset_line_out  <= 1'b0;
						reset_line_oe_n <= 1'b0;
						state           <= S_RSOUT;
					end
					// a stale acknowledge from the last cycle lengthens the next start
					else if ((booting || cyc_req) && !stop && !ack && bus_own)
					begin
						lt_write <= booting ? 1'b0 : cyc_write;
						lt_rmw   <= booting ? 1'b0 : cyc_rmw;
						lt_addr  <= booting ? boot_addr(boot_word) : cyc_addr;
						lt_wdata <= cyc_wdata;
						lt_fc    <= booting ? `BTH_FC_SUPER_DATA : cyc_fc;
						addr_out <= booting ? boot_addr(boot_word) : cyc_addr;
						fc_out   <= booting ? `BTH_FC_SUPER_DATA : cyc_fc;
						rw_out   <= booting ? 1'b1 : ~cyc_write;
						data_out <= cyc_wdata;
						data_oe_n <= booting | ~cyc_write;
						addr_oe_n <= 1'b0;
						state    <= S_ADDR;
					end
				end
				S_ADDR:
				begin
					addr_strobe_n <= 1'b0;
					state         <= S_WAIT;
				end
				S_WAIT:
				begin
					// fault is looked at on every cycle of the wait
					if (fault && stop && !lt_rmw)
					begin
						addr_strobe_n <= 1'b1;
						addr_oe_n     <= 1'b1;
						data_oe_n     <= 1'b1;
						halted        <= 1'b1;
						state         <= S_RERUN;
					end
					else if (fault && !ack)
						state <= S_FEXT;
					else if (fault)
					begin
						addr_strobe_n <= 1'b1;
						addr_oe_n     <= 1'b1;
						data_oe_n     <= 1'b1;
						state         <= S_BUS_FAULT_IN;
					end
					else if (ack)
					begin
						addr_strobe_n <= 1'b1;
						data_oe_n     <= 1'b1;
						cyc_rdata     <= data_in;
						if (booting)
						begin
							case (boot_word)
							2'h0: supervisor_stack_ptr[31:16] <= data_in;
							2'h1: supervisor_stack_ptr[15:0]  <= data_in;
							2'h2: prog_counter[31:16]         <= data_in;
							default: prog_counter[15:0]       <= data_in;
							endcase
							boot_word <= boot_word + 2'h1;
							if (boot_word == 2'h3)
							begin
								booting   <= 1'b0;
								boot_done <= 1'b1;
							end
						end
						else
							cyc_done <= 1'b1;
						if (stop)
						begin
							addr_oe_n <= 1'b1;
							halted    <= 1'b1;
							state     <= S_HALT;
						end
						else
							state <= S_IDLE;
					end
				end
				S_FEXT:
				begin
					// extra clock for a fault that came without acknowledge
					addr_strobe_n <= 1'b1;
					addr_oe_n     <= 1'b1;
					data_oe_n     <= 1'b1;
					if (stop && !lt_rmw)
					begin
						halted <= 1'b1;
						state  <= S_RERUN;
					end
					else
						state <= S_BUS_FAULT_IN;
				end
				S_RERUN:
				begin
					if (!stop && !fault && !ack)
					begin
						halted    <= 1'b0;
						addr_out  <= lt_addr;
						fc_out    <= lt_fc;
						rw_out    <= ~lt_write;
						data_out  <= lt_wdata;
						data_oe_n <= ~lt_write;
						addr_oe_n <= 1'b0;
						state     <= bus_own ? S_ADDR : S_RERUN;
						if (!bus_own)
							halted <= 1'b1;
					end
				end
				S_BUS_FAULT_IN:
				begin
					// lines float while the fault is still asserted
					if (!fault)
					begin
						if (fault_armed || booting)
						begin
							halted    <= 1'b1;
							dbl_fault <= 1'b1;
							state     <= S_DFLT;
						end
						else
						begin
							fault_armed <= 1'b1;
							cyc_err     <= 1'b1;
							trap_req    <= 1'b1;
							trap_addr   <= `BTH_VEC_BUS_FAULT_IN_ADDR;
							state       <= S_IDLE;
						end
					end
				end
				S_HALT:
				begin
					if (!stop)
					begin
						halted <= 1'b0;
						state  <= S_IDLE;
					end
				end
				S_DFLT:
				begin
					// only a full reset leaves this state
					state <= S_DFLT;
				end
				S_RSOUT:
				begin
					if (rs_out_cnt == RST_OUT_CYCLES[7:0] - 8'h01)
					begin
						reset_line_out  <= 1'b1;
						reset_line_oe_n <= 1'b1;
						cyc_done        <= 1'b1;
						state           <= S_IDLE;
					end
					else
						rs_out_cnt <= rs_out_cnt + 8'h01;
				end
				default:
					state <= S_IDLE;
				endcase
			end
		end
	end

endmodule

/* File: test/bth_bus_term_chk.sv */
// checker for the bus termination, halt and reset controller
// assumes it is bound to bth_bus_term and sees only its ports
`timescale 1ns/1ps
module bth_bus_term_chk #(
	parameter RST_OUT_CYCLES = 124
) (
	input wire        mclk,
	input wire        rst_b,
	input wire        transfer_ack_n,
	input wire        bus_fault_in,
	input wire        stop_line,
	input wire        reset_line_in,
	input wire        bus_req_n,
	input wire        reset_line_oe_n,
	input wire        addr_oe_n,
	input wire        data_oe_n,
	input wire        addr_strobe_n,
	input wire        bus_grant_n,
	input wire        cyc_err,
	input wire        trap_req,
	input wire [23:0] trap_addr,
	input wire        halted,
	input wire        dbl_fault,
	input wire [2:0]  ipl,
	input wire        boot_done
);
	reg [7:0] drive_cnt;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	always @(posedge mclk or negedge rst_b)
		if (!rst_b)
			drive_cnt <= 8'h00;
		else
			drive_cnt <= reset_line_oe_n ? 8'h00 : drive_cnt + 8'h01;
	property p_quiet; halted |-> addr_strobe_n; endproperty
	a_quiet: assert property (p_quiet) else $error("strobe while halted");
	property p_float; stop_line && $past(stop_line, 2) && $fell(transfer_ack_n) && !addr_strobe_n
		|-> ##[1:8] (addr_oe_n && data_oe_n); endproperty
	a_float: assert property (p_float) else $error("bus not floated");
	property p_trap; cyc_err |-> trap_req ##1 trap_addr == 24'h000008; endproperty
	a_trap: assert property (p_trap) else $error("bad trap");
	property p_len; $rose(reset_line_oe_n) |-> drive_cnt == RST_OUT_CYCLES; endproperty
	a_len: assert property (p_len) else $error("reset drive length");
	property p_ipl; boot_done |-> ipl == 3'h7; endproperty
	a_ipl: assert property (p_ipl) else $error("priority not seven");
	property p_hold; dbl_fault && reset_line_in |=> dbl_fault && halted; endproperty
	a_hold: assert property (p_hold) else $error("double fault left");
	property p_end; $fell(transfer_ack_n) && !addr_strobe_n && !bus_fault_in && !stop_line
		|-> ##[1:8] addr_strobe_n; endproperty
	a_end: assert property (p_end) else $error("cycle not ended");
	property p_grant; bus_req_n [*5] |-> bus_grant_n; endproperty
	a_grant: assert property (p_grant) else $error("grant without request");
	c_err: cover property (cyc_err);
	c_dbl: cover property ($rose(dbl_fault));
	c_len: cover property ($rose(reset_line_oe_n));
endmodule

bind bth_bus_term bth_bus_term_chk #(.RST_OUT_CYCLES(RST_OUT_CYCLES)) bth_bus_term_chk_inst (
	.mclk(mclk), .rst_b(rst_b), .transfer_ack_n(transfer_ack_n), .bus_fault_in(bus_fault_in),
	.stop_line(stop_line), .reset_line_in(reset_line_in), .bus_req_n(bus_req_n),
	.reset_line_oe_n(reset_line_oe_n), .addr_oe_n(addr_oe_n), .data_oe_n(data_oe_n),
	.addr_strobe_n(addr_strobe_n), .bus_grant_n(bus_grant_n), .cyc_err(cyc_err),
	.trap_req(trap_req), .trap_addr(trap_addr), .halted(halted), .dbl_fault(dbl_fault),
	.ipl(ipl), .boot_done(boot_done));

/* File: test/bth_slave_model.sv */
// memory slave answering bus cycles with acknowledge three clocks into the strobe
// assumes the bench withholds acknowledge through no_ack when it injects faults
`timescale 1ns/1ps
module bth_slave_model (
	input  wire        mclk,
	input  wire        addr_strobe_n,
	input  wire [23:0] addr_out,
	input  wire        no_ack,
	output reg         transfer_ack_n,
	output reg  [15:0] data_in
);
	reg [1:0] wait_cnt;
	initial
	begin
		transfer_ack_n = 1'b1;
		data_in = 16'h0000;
		wait_cnt = 2'h0;
	end
	always @(posedge mclk)
	begin
		wait_cnt <= addr_strobe_n ? 2'h0 : wait_cnt + {1'b0, wait_cnt != 2'h3};
		transfer_ack_n <= addr_strobe_n | no_ack | (wait_cnt < 2'h2);
		// released bus shows a changing pattern, not the last value
		data_in <= addr_strobe_n ? ~data_in : addr_out[15:0] ^ 16'h5a3c;
	end
endmodule

/* File: test/bth_bus_term_bench.sv */
// self-checking bench for the bus termination, halt and reset controller
// assumes bth_slave_model answers cycles; bus request lines are left idle
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run = tests_run + 1; if ((g) !== (e)) begin \
	failures = failures + 1; $display("mismatch %s expected %h seen %h", n, e, g); end end
module bth_bus_term_bench;
	localparam [15:0] KEY = 16'h5a3c;
	reg         mclk, rst_b, cyc_req, cyc_write, cyc_rmw, insn_start, reset_insn;
	reg         bus_fault_in, stop_line, ext_rst_n, no_ack;
	reg  [23:0] cyc_addr;
	reg  [15:0] cyc_wdata;
	reg  [2:0]  cyc_fc;
	wire        transfer_ack_n, reset_line_out, reset_line_oe_n, addr_oe_n, data_oe_n;
	wire        rw_out, addr_strobe_n, bus_grant_n, cyc_done, cyc_err, trap_req;
	wire        halted, dbl_fault, boot_done;
	wire [15:0] data_in, data_out, cyc_rdata;
	wire [23:0] addr_out, trap_addr;
	wire [31:0] supervisor_stack_ptr, prog_counter, ssp_keep;
	wire [2:0]  fc_out, ipl;
	wire        reset_line_in = (reset_line_oe_n | reset_line_out) & ext_rst_n;
	integer     failures, tests_run, cycles, n;
	bth_bus_term #(.RST_OUT_CYCLES(124), .SYSRST_CYCLES(10)) bth_bus_term_inst (
		.mclk(mclk), .rst_b(rst_b), .cyc_req(cyc_req), .cyc_write(cyc_write),
		.cyc_rmw(cyc_rmw), .cyc_addr(cyc_addr), .cyc_wdata(cyc_wdata), .cyc_fc(cyc_fc),
		.insn_start(insn_start), .reset_insn(reset_insn), .transfer_ack_n(transfer_ack_n),
		.bus_fault_in(bus_fault_in), .stop_line(stop_line), .reset_line_in(reset_line_in),
		.bus_req_n(1'b1), .bus_gack_n(1'b1), .data_in(data_in),
		.reset_line_out(reset_line_out), .reset_line_oe_n(reset_line_oe_n),
		.addr_out(addr_out), .addr_oe_n(addr_oe_n), .data_out(data_out),
		.data_oe_n(data_oe_n), .fc_out(fc_out), .rw_out(rw_out),
		.addr_strobe_n(addr_strobe_n), .bus_grant_n(bus_grant_n), .cyc_done(cyc_done),
		.cyc_err(cyc_err), .cyc_rdata(cyc_rdata), .trap_req(trap_req),
		.trap_addr(trap_addr), .halted(halted), .dbl_fault(dbl_fault),
		.supervisor_stack_ptr(supervisor_stack_ptr), .prog_counter(prog_counter),
		.ipl(ipl), .boot_done(boot_done));
	bth_slave_model bth_slave_model_inst (.mclk(mclk), .addr_strobe_n(addr_strobe_n),
		.addr_out(addr_out), .no_ack(no_ack), .transfer_ack_n(transfer_ack_n),
		.data_in(data_in));
	assign ssp_keep = {16'h0000 ^ KEY, 16'h0002 ^ KEY};
	always #10 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cycles = cycles + 1;
		if (cycles == 20000)
		begin
			failures = failures + 1;
			print_verdict;
		end
	end
	task step(input integer k);
		repeat (k)
		begin
			@(posedge mclk);
			#2;
		end
	endtask
	// 0: strobe low, 1: any completion pulse
	task wait_for(input integer w);
		integer g;
		begin
			g = 0;
			step(1);
			while (g < 400 && !(w == 0 ? addr_strobe_n === 1'b0
				: (cyc_done | cyc_err | boot_done) === 1'b1))
			begin
				step(1);
				g = g + 1;
			end
		end
	endtask
	task print_verdict;
		begin
			if (failures == 0 && tests_run > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	task s_boot;
		begin
			wait_for(1);
			`CHK("ssp", ssp_keep, supervisor_stack_ptr)
			`CHK("pc", {16'h0004 ^ KEY, 16'h0006 ^ KEY}, prog_counter)
			`CHK("ipl", 3'h7, ipl)
			insn_start = 1'b1;
			step(1);
			insn_start = 1'b0;
		end
	endtask
	task s_normal;
		begin
			cyc_addr = 24'h000100;
			cyc_req = 1'b1;
			for (n = 0; n < 2; n = n + 1)
			begin
				wait_for(1);
				`CHK("rdata", cyc_addr[15:0] ^ KEY, cyc_rdata)
				cyc_addr = 24'h000202;
			end
			cyc_req = 1'b0;
		end
	endtask
	task s_halt;
		begin
			stop_line = 1'b1;
			step(6);
			cyc_req = 1'b1;
			step(20);
			`CHK("held", 1'b1, addr_strobe_n)
			stop_line = 1'b0;
			wait_for(0);
			stop_line = 1'b1;
			wait_for(1);
			cyc_req = 1'b0;
			`CHK("step", 1'b1, cyc_done)
			step(4);
			`CHK("halted", 1'b1, halted)
			`CHK("float", 1'b1, addr_oe_n)
			stop_line = 1'b0;
			step(8);
			`CHK("resumed", 1'b0, halted)
		end
	endtask
	task s_rerun;
		integer i;
		begin
			{cyc_addr, cyc_wdata, cyc_write, cyc_fc, cyc_req} = {24'h000400, 16'h1234, 5'h15};
			for (i = 0; i < 2; i = i + 1)
			begin
				no_ack = 1'b1;
				wait_for(0);
				bus_fault_in = 1'b1;
				step(i);
				stop_line = 1'b1;
				step(10);
				`CHK("rerun halt", 1'b1, halted)
				`CHK("float", 1'b1, data_oe_n)
				bus_fault_in = 1'b0;
				step(2);
				{stop_line, no_ack} = 2'h0;
				wait_for(0);
				`CHK("addr", 24'h000400, addr_out)
				`CHK("data", 16'h1234, data_out)
				`CHK("fc", 3'h2, fc_out)
				`CHK("rw", 1'b0, rw_out)
			end
			wait_for(1);
			{cyc_req, cyc_write} = 2'h0;
			`CHK("done", 1'b1, cyc_done)
			`CHK("dbl", 1'b0, dbl_fault)
		end
	endtask
	task pin_reset;
		begin
			{ext_rst_n, stop_line} = 2'h1;
			step(16);
			{ext_rst_n, stop_line} = 2'h2;
		end
	endtask
	task fault_cycle;
		begin
			wait_for(0);
			bus_fault_in = 1'b1;
			step(8);
			bus_fault_in = 1'b0;
			step(6);
		end
	endtask
	task s_fault;
		begin
			{cyc_rmw, cyc_req, no_ack} = 3'h7;
			wait_for(0);
			{bus_fault_in, stop_line} = 2'h3;
			step(8);
			{bus_fault_in, stop_line} = 2'h0;
			wait_for(1);
			{cyc_rmw, cyc_req} = 2'h0;
			`CHK("rmw err", 1'b1, cyc_err)
			step(1);
			`CHK("vector", 24'h000008, trap_addr)
			cyc_req = 1'b1;
			fault_cycle;
			cyc_req = 1'b0;
			`CHK("dbl", 1'b1, dbl_fault)
			stop_line = 1'b1;
			step(6);
			stop_line = 1'b0;
			step(6);
			`CHK("dbl held", 1'b1, dbl_fault)
			pin_reset;
			fault_cycle;
			`CHK("boot dbl", 1'b1, dbl_fault)
			no_ack = 1'b0;
			pin_reset;
			s_boot;
			`CHK("dbl clear", 1'b0, dbl_fault)
		end
	endtask
	task s_rst_insn;
		begin
			reset_insn = 1'b1;
			step(1);
			reset_insn = 1'b0;
			n = 0;
			while (reset_line_oe_n !== 1'b0 && n < 3)
			begin
				n = n + 1;
				step(1);
			end
			n = 0;
			while (reset_line_oe_n === 1'b0 && n < 300)
			begin
				n = n + 1;
				step(1);
			end
			`CHK("drive", 124, n)
			`CHK("ssp kept", ssp_keep, supervisor_stack_ptr)
		end
	endtask
	initial
	begin
		{mclk, rst_b, cyc_req, cyc_write, cyc_rmw, insn_start, reset_insn} = 7'h00;
		{bus_fault_in, stop_line, no_ack, ext_rst_n} = 4'h1;
		{cyc_addr, cyc_wdata, cyc_fc} = 43'h0;
		{failures, tests_run, cycles, n} = 128'h0;
		repeat (12) @(posedge mclk);
		#2;
		rst_b = 1'b1;
		s_boot;
		s_normal;
		s_halt;
		s_rerun;
		s_fault;
		s_rst_insn;
		print_verdict;
	end
endmodule
